// file: ghs_handshake.sv
`timescale 1ns/1ps
module ghs_handshake #(
    parameter int DATA_W = ghs_pkg::DATA_W,
    parameter int SETTLE_CYC = ghs_pkg::SETTLE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    // local side
    input wire logic [4:0] own_addr,
    input wire logic ctrl_init,
    input wire logic ctrl_attention,
    input wire logic ctrl_remote,
    input wire logic ctrl_srq_enable,
    input wire logic ctrl_poll_done,
    input wire logic req_srq,
    input wire logic talk_en,
    input wire logic listen_en,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [15:0] rx_count,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_last,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_done,
    output logic srq_pending,
    output logic ifc_seen,
    output logic atn_seen,
    output logic ren_seen,
    output logic hs_error,
    output logic addr_ok,
    // bus pins, active low, open collector
    input wire logic [DATA_W-1:0] dio_n_in,
    output logic [DATA_W-1:0] dio_n_out,
    output logic [DATA_W-1:0] dio_n_oe_n,
    input wire logic dav_n_in,
    output logic dav_n_out,
    output logic dav_n_oe_n,
    input wire logic nrfd_n_in,
    output logic nrfd_n_out,
    output logic nrfd_n_oe_n,
    input wire logic ndac_n_in,
    output logic ndac_n_out,
    output logic ndac_n_oe_n,
    input wire logic eoi_n_in,
    output logic eoi_n_out,
    output logic eoi_n_oe_n,
    input wire logic ifc_n_in,
    output logic ifc_n_out,
    output logic ifc_n_oe_n,
    input wire logic atn_n_in,
    output logic atn_n_out,
    output logic atn_n_oe_n,
    input wire logic srq_n_in,
    output logic srq_n_out,
    output logic srq_n_oe_n,
    input wire logic ren_n_in,
    output logic ren_n_out,
    output logic ren_n_oe_n
);
    localparam int SW = DATA_W + 8;

    ghs_sync_if #(.W(SW)) sif ();

    assign sif.raw = {dio_n_in, dav_n_in, nrfd_n_in, ndac_n_in, eoi_n_in,
                      ifc_n_in, atn_n_in, srq_n_in, ren_n_in};

    ghs_sync #(.W(SW)) u_sync (
        .clock(clock),
        .rst(rst),
        .sif(sif)
    );

    // logical values: pins are active low, wired-OR by open collector
    logic [DATA_W-1:0] bus_data;
    logic bus_dav;
    logic bus_nrfd;
    logic bus_ndac;
    logic bus_eoi;
    logic bus_ifc;
    logic bus_atn;
    logic bus_srq;
    logic bus_ren;
    assign bus_data = ~sif.synced[SW-1:8];
    assign bus_dav = ~sif.synced[7];
    assign bus_nrfd = ~sif.synced[6];
    assign bus_ndac = ~sif.synced[5];
    assign bus_eoi = ~sif.synced[4];
    assign bus_ifc = ~sif.synced[3];
    assign bus_atn = ~sif.synced[2];
    assign bus_srq = ~sif.synced[1];
    assign bus_ren = ~sif.synced[0];

    function automatic logic addr_legal(input logic [4:0] a);
        addr_legal = (a >= 5'(ghs_pkg::ADDR_MIN)) && (a <= 5'(ghs_pkg::ADDR_MAX));
    endfunction : addr_legal

    ghs_pkg::ghs_state_t state;
    ghs_pkg::ghs_state_t next_state;
    logic [15:0] settle_cnt;
    logic [15:0] next_settle_cnt;
    logic [15:0] rx_seen;
    logic [15:0] next_rx_seen;
    logic [DATA_W-1:0] drv_data;
    logic [DATA_W-1:0] next_drv_data;
    logic drv_dav;
    logic next_drv_dav;
    logic drv_eoi;
    logic next_drv_eoi;
    logic drv_nrfd;
    logic next_drv_nrfd;
    logic drv_ndac;
    logic next_drv_ndac;
    logic [DATA_W-1:0] next_rx_data;
    logic next_rx_last;
    logic next_rx_valid;
    logic next_rx_done;
    logic next_srq_pending;
    logic next_hs_error;
    logic halt;

    // bus clear or attention abort any transfer in flight
    assign halt = bus_ifc || bus_atn || ctrl_init || ctrl_attention;
    assign tx_ready = (state == ghs_pkg::GHS_T_CHECK) && !halt && talk_en
                      && (bus_nrfd || bus_ndac);

    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_rx_seen = rx_seen;
        next_drv_data = drv_data;
        next_drv_dav = drv_dav;
        next_drv_eoi = drv_eoi;
        next_drv_nrfd = drv_nrfd;
        next_drv_ndac = drv_ndac;
        next_rx_data = rx_data;
        next_rx_last = rx_last;
        next_rx_valid = rx_valid && !rx_ready;
        next_rx_done = 1'b0;
        next_hs_error = hs_error;
        // set wins over the poll-done clear
        next_srq_pending = (srq_pending && !ctrl_poll_done)
                           || (ctrl_srq_enable && bus_srq);
        if (halt) begin
            next_state = ghs_pkg::GHS_IDLE;
            next_drv_dav = 1'b0;
            next_drv_eoi = 1'b0;
            next_drv_nrfd = 1'b0;
            next_drv_ndac = 1'b0;
            next_rx_seen = '0;
            if (bus_ifc || ctrl_init) begin
                next_hs_error = 1'b0;
                next_rx_valid = 1'b0;
            end
        end else begin
            case (state)
                ghs_pkg::GHS_IDLE: begin
                    next_drv_dav = 1'b0;
                    next_drv_nrfd = 1'b0;
                    next_drv_ndac = 1'b0;
                    if (talk_en) begin
                        next_state = ghs_pkg::GHS_T_CHECK;
                    end else if (listen_en && addr_legal(own_addr)) begin
                        // listeners enter holding both lines
                        next_drv_nrfd = 1'b1;
                        next_drv_ndac = 1'b1;
                        next_rx_seen = '0;
                        next_state = ghs_pkg::GHS_L_READY;
                    end
                end
                ghs_pkg::GHS_T_CHECK: begin
                    if (!talk_en) begin
                        next_state = ghs_pkg::GHS_IDLE;
                    end else if (!bus_nrfd && !bus_ndac) begin
                        next_hs_error = 1'b1;
                    end else if (tx_valid) begin
                        next_drv_data = tx_data;
                        next_drv_eoi = tx_last;
                        next_settle_cnt = 16'(SETTLE_CYC);
                        next_state = ghs_pkg::GHS_T_SETTLE;
                    end
                end
                ghs_pkg::GHS_T_SETTLE: begin
                    // settle time lets slow receivers see stable data
                    if (settle_cnt > 16'h0001) begin
                        next_settle_cnt = settle_cnt - 16'h0001;
                    end else begin
                        next_state = ghs_pkg::GHS_T_WAIT_RFD;
                    end
                end
                ghs_pkg::GHS_T_WAIT_RFD: begin
                    if (!bus_nrfd) begin
                        next_drv_dav = 1'b1;
                        next_state = ghs_pkg::GHS_T_WAIT_DAC;
                    end
                end
                ghs_pkg::GHS_T_WAIT_DAC: begin
                    // byte and end flag stay put until every listener accepts
                    if (!bus_ndac) begin
                        next_drv_dav = 1'b0;
                        next_drv_eoi = 1'b0;
                        next_state = ghs_pkg::GHS_T_CHECK;
                    end
                end
                ghs_pkg::GHS_L_READY: begin
                    if (!listen_en) begin
                        next_state = ghs_pkg::GHS_IDLE;
                    end else if (!rx_valid || rx_ready) begin
                        next_drv_nrfd = 1'b0;
                        if (bus_dav) begin
                            next_drv_nrfd = 1'b1;
                            next_rx_data = bus_data;
                            next_rx_last = bus_eoi;
                            next_rx_valid = 1'b1;
                            next_rx_seen = rx_seen + 16'h0001;
                            next_state = ghs_pkg::GHS_L_ACCEPT;
                        end
                    end
                end
                ghs_pkg::GHS_L_ACCEPT: begin
                    next_drv_ndac = 1'b0;
                    next_state = ghs_pkg::GHS_L_WAIT_DAV_LOW;
                    if (rx_last || rx_seen >= rx_count) begin
                        next_rx_done = rx_last;
                    end
                end
                ghs_pkg::GHS_L_WAIT_DAV_LOW: begin
                    if (!bus_dav) begin
                        next_drv_ndac = 1'b1;
                        next_state = ghs_pkg::GHS_L_READY;
                    end
                end
                default: begin
                    next_state = ghs_pkg::GHS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ghs_pkg::GHS_IDLE;
            settle_cnt <= '0;
            rx_seen <= '0;
            drv_data <= '0;
            drv_dav <= 1'b0;
            drv_eoi <= 1'b0;
            drv_nrfd <= 1'b0;
            drv_ndac <= 1'b0;
            rx_data <= '0;
            rx_last <= 1'b0;
            rx_valid <= 1'b0;
            rx_done <= 1'b0;
            srq_pending <= 1'b0;
            hs_error <= 1'b0;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            rx_seen <= next_rx_seen;
            drv_data <= next_drv_data;
            drv_dav <= next_drv_dav;
            drv_eoi <= next_drv_eoi;
            drv_nrfd <= next_drv_nrfd;
            drv_ndac <= next_drv_ndac;
            rx_data <= next_rx_data;
            rx_last <= next_rx_last;
            rx_valid <= next_rx_valid;
            rx_done <= next_rx_done;
            srq_pending <= next_srq_pending;
            hs_error <= next_hs_error;
        end
    end
    // status flags: registered copies of the bus, plus the registered own_addr range check (addr_ok)
    logic next_ifc_seen;
    logic next_atn_seen;
    logic next_ren_seen;
    always_comb begin
        next_ifc_seen = bus_ifc;
        next_atn_seen = bus_atn;
        next_ren_seen = bus_ren;
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            ifc_seen <= 1'b0;
            atn_seen <= 1'b0;
            ren_seen <= 1'b0;
            addr_ok <= 1'b0;
        end else begin
            ifc_seen <= next_ifc_seen;
            atn_seen <= next_atn_seen;
            ren_seen <= next_ren_seen;
            addr_ok <= addr_legal(own_addr);
        end
    end

    // open collector: pull low when asserted, else release
    logic talking;
    assign talking = (state == ghs_pkg::GHS_T_SETTLE) || (state == ghs_pkg::GHS_T_WAIT_RFD)
                     || (state == ghs_pkg::GHS_T_WAIT_DAC);
    assign dio_n_out = '0;
    assign dio_n_oe_n = ~(drv_data & {DATA_W{talking}});
    assign dav_n_out = 1'b0;
    assign dav_n_oe_n = ~drv_dav;
    assign nrfd_n_out = 1'b0;
    assign nrfd_n_oe_n = ~drv_nrfd;
    assign ndac_n_out = 1'b0;
    assign ndac_n_oe_n = ~drv_ndac;
    assign eoi_n_out = 1'b0;
    assign eoi_n_oe_n = ~(drv_eoi && drv_dav);
    assign ifc_n_out = 1'b0;
    assign ifc_n_oe_n = ~ctrl_init;
    assign atn_n_out = 1'b0;
    assign atn_n_oe_n = ~ctrl_attention;
    assign srq_n_out = 1'b0;
    assign srq_n_oe_n = ~req_srq;
    assign ren_n_out = 1'b0;
    assign ren_n_oe_n = ~ctrl_remote;
endmodule : ghs_handshake

// file: ghs_handshake_checker.sv
`timescale 1ns/1ps
module ghs_handshake_checker #(
    parameter int DATA_W = 8,
    parameter int SETTLE_CYC = 100
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] own_addr,
    input wire logic ctrl_init,
    input wire logic ctrl_remote,
    input wire logic ctrl_poll_done,
    input wire logic srq_pending,
    input wire logic atn_seen,
    input wire logic hs_error,
    input wire logic addr_ok,
    input wire logic nrfd_n_in,
    input wire logic ndac_n_in,
    input wire logic [DATA_W-1:0] dio_n_oe_n,
    input wire logic dav_n_oe_n,
    input wire logic nrfd_n_oe_n,
    input wire logic ndac_n_oe_n,
    input wire logic eoi_n_oe_n,
    input wire logic ifc_n_oe_n,
    input wire logic ren_n_oe_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // two sync flops plus the drv_dav register
    sequence s_dav_up;
        $fell(dav_n_oe_n);
    endsequence
    sequence s_dav_down;
        $rose(dav_n_oe_n);
    endsequence
    chk_dav_after_rfd: assert property (s_dav_up |-> $past(nrfd_n_in, 3))
        else $error("valid before ready");
    chk_dav_after_dac: assert property (s_dav_down |-> $past(ndac_n_in, 3))
        else $error("valid dropped before accept");
    chk_eoi_with_byte: assert property (s_dav_down |-> eoi_n_oe_n)
        else $error("end flag outlived byte");
    chk_data_held: assert property (
        !dav_n_oe_n && !$past(dav_n_oe_n) |-> $stable(dio_n_oe_n))
        else $error("data changed while valid");
    chk_ifc_drive: assert property (ctrl_init |-> !ifc_n_oe_n)
        else $error("clear not driven");
    chk_ren_drive: assert property (ren_n_oe_n == !ctrl_remote)
        else $error("remote line wrong");
    chk_atn_quiet: assert property (
        atn_seen && $past(atn_seen) |-> dav_n_oe_n && nrfd_n_oe_n && ndac_n_oe_n)
        else $error("handshake active under attention");
    chk_err_sticky: assert property (hs_error && !ctrl_init |=> hs_error)
        else $error("error flag lost");
    chk_srq_sticky: assert property (
        srq_pending && !ctrl_poll_done && !ctrl_init |=> srq_pending)
        else $error("service flag lost");
    chk_addr_range: assert property (
        !$past(rst) |-> addr_ok == ($past(own_addr) inside {[5'h01:5'h1E]}))
        else $error("address check wrong");
endmodule : ghs_handshake_checker
bind ghs_handshake ghs_handshake_checker #(.DATA_W(DATA_W), .SETTLE_CYC(SETTLE_CYC)) u_chk (
    .clock(clock), .rst(rst), .own_addr(own_addr), .ctrl_init(ctrl_init),
    .ctrl_remote(ctrl_remote), .ctrl_poll_done(ctrl_poll_done), .srq_pending(srq_pending),
    .atn_seen(atn_seen), .hs_error(hs_error), .addr_ok(addr_ok), .nrfd_n_in(nrfd_n_in),
    .ndac_n_in(ndac_n_in), .dio_n_oe_n(dio_n_oe_n), .dav_n_oe_n(dav_n_oe_n),
    .nrfd_n_oe_n(nrfd_n_oe_n), .ndac_n_oe_n(ndac_n_oe_n), .eoi_n_oe_n(eoi_n_oe_n),
    .ifc_n_oe_n(ifc_n_oe_n), .ren_n_oe_n(ren_n_oe_n));

// file: ghs_handshake_test.sv
`timescale 1ns/1ps
module ghs_handshake_test;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [4:0] own_addr = 5'h01;
    logic c_init = 1'h0, c_atn = 1'h0, c_ren = 1'h0, c_srqen = 1'h0, c_poll = 1'h0;
    logic req_srq = 1'h0, p_srq = 1'h1, talk_en = 1'h0, listen_en = 1'h0;
    logic tx_last = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data, d_dio, p1_dio, p2_dio;
    logic tx_ready, rx_last, rx_valid, rx_done, srq_pending, ifc_seen, atn_seen, ren_seen;
    logic hs_error, addr_ok, d_dav, d_nrfd, d_ndac, d_eoi, d_ifc, d_atn, d_srq, d_ren;
    logic p1_dav, p1_nrfd, p1_ndac, p1_eoi, p2_dav, p2_nrfd, p2_ndac, p2_eoi;
    int n_errors = 0, checks_done = 0, n_done = 0;
    // wired-and of all parties, pull-up when released
    wire [7:0] dio_n = d_dio & p1_dio & p2_dio;
    wire dav_n = d_dav & p1_dav & p2_dav;
    wire nrfd_n = d_nrfd & p1_nrfd & p2_nrfd;
    wire ndac_n = d_ndac & p1_ndac & p2_ndac;
    wire eoi_n = d_eoi & p1_eoi & p2_eoi;
    wire srq_n = d_srq & p_srq;
    ghs_handshake #(.SETTLE_CYC(2)) dut (
        .clock(clock), .rst(rst), .own_addr(own_addr), .ctrl_init(c_init),
        .ctrl_attention(c_atn), .ctrl_remote(c_ren), .ctrl_srq_enable(c_srqen),
        .ctrl_poll_done(c_poll), .req_srq(req_srq), .talk_en(talk_en), .listen_en(listen_en),
        .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_count(16'h0003), .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_done(rx_done), .srq_pending(srq_pending), .ifc_seen(ifc_seen),
        .atn_seen(atn_seen), .ren_seen(ren_seen), .hs_error(hs_error), .addr_ok(addr_ok),
        .dio_n_in(dio_n), .dio_n_out(), .dio_n_oe_n(d_dio), .dav_n_in(dav_n), .dav_n_out(),
        .dav_n_oe_n(d_dav), .nrfd_n_in(nrfd_n), .nrfd_n_out(), .nrfd_n_oe_n(d_nrfd),
        .ndac_n_in(ndac_n), .ndac_n_out(), .ndac_n_oe_n(d_ndac), .eoi_n_in(eoi_n),
        .eoi_n_out(), .eoi_n_oe_n(d_eoi), .ifc_n_in(d_ifc), .ifc_n_out(), .ifc_n_oe_n(d_ifc),
        .atn_n_in(d_atn), .atn_n_out(), .atn_n_oe_n(d_atn), .srq_n_in(srq_n), .srq_n_out(),
        .srq_n_oe_n(d_srq), .ren_n_in(d_ren), .ren_n_out(), .ren_n_oe_n(d_ren));
    ghs_peer p1 (.clock(clock), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
        .ndac_n(ndac_n), .eoi_n(eoi_n), .dio_oe_n(p1_dio), .dav_oe_n(p1_dav),
        .nrfd_oe_n(p1_nrfd), .ndac_oe_n(p1_ndac), .eoi_oe_n(p1_eoi));
    ghs_peer p2 (.clock(clock), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
        .ndac_n(ndac_n), .eoi_n(eoi_n), .dio_oe_n(p2_dio), .dav_oe_n(p2_dav),
        .nrfd_oe_n(p2_nrfd), .ndac_oe_n(p2_ndac), .eoi_oe_n(p2_eoi));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic t_addr;
        logic [4:0] a[4] = '{5'h00, 5'h01, 5'h1E, 5'h1F};
        check({d_dav, d_nrfd, d_ndac, d_eoi, hs_error, srq_pending, rx_valid}, 9'h078);
        foreach (a[i]) begin
            own_addr = a[i];
            cyc(2);
            check(addr_ok, (i == 1 || i == 2));
        end
        $display("test addr done");
    endtask : t_addr
    task automatic t_talk;
        logic [7:0] b[3] = '{8'hA5, 8'h00, 8'hFF};
        // second listener slower: bus waits for it
        fork
            p1.listen(3, 1);
            p2.listen(3, 7);
        join_none
        // listeners hold both lines first, else the talker sees a false 0,0
        cyc(4);
        talk_en = 1'h1;
        cyc(4);
        tx_valid = 1'h1;
        foreach (b[i]) begin
            tx_data = b[i];
            tx_last = (i == 2);
            for (int k = 0; k < 400; k++) begin
                @(posedge clock);
                if (tx_ready === 1'h1) break;
            end
            #1;
        end
        tx_valid = 1'h0;
        wait fork;
        talk_en = 1'h0;
        check(hs_error, 9'h000);
        for (int i = 0; i < 3; i++) begin
            check(p1.q[i], {i == 2, b[i]});
            check(p2.q[i], {i == 2, b[i]});
        end
        $display("test talk done");
    endtask : t_talk
    task automatic t_listen;
        // the address test leaves an illegal address behind
        own_addr = 5'h05;
        listen_en = 1'h1;
        cyc(4);
        p1.talk(8'h3C, 1'h0, 2);
        cyc(1);
        fork
            p1.talk(8'hC3, 1'h1, 2);
            begin
                cyc(20);
                check(nrfd_n, 1'h0);
                check({rx_last, rx_data}, 9'h03C);
                rx_ready = 1'h1;
                cyc(1);
                rx_ready = 1'h0;
            end
        join
        cyc(4);
        check({rx_last, rx_data}, 9'h1C3);
        check(n_done, 9'h001);
        rx_ready = 1'h1;
        listen_en = 1'h0;
        cyc(4);
        check({d_nrfd, d_ndac, rx_valid}, 9'h006);
        rx_ready = 1'h0;
        $display("test listen done");
    endtask : t_listen
    task automatic t_err;
        talk_en = 1'h1;
        tx_valid = 1'h1;
        cyc(10);
        check({hs_error, d_dav}, 9'h003);
        tx_valid = 1'h0;
        talk_en = 1'h0;
        c_init = 1'h1;
        cyc(4);
        check({d_ifc, ifc_seen, hs_error}, 9'h002);
        c_init = 1'h0;
        cyc(4);
        check(ifc_seen, 9'h000);
        $display("test error done");
    endtask : t_err
    task automatic t_mgmt;
        c_atn = 1'h1;
        c_ren = 1'h1;
        req_srq = 1'h1;
        cyc(4);
        check({d_atn, atn_seen, d_ren, ren_seen, d_srq, srq_pending}, 9'h014);
        c_atn = 1'h0;
        req_srq = 1'h0;
        c_srqen = 1'h1;
        p_srq = 1'h0;
        cyc(4);
        check(srq_pending, 9'h001);
        p_srq = 1'h1;
        // let the released line clear the synchroniser, else set wins over the clear
        cyc(3);
        c_poll = 1'h1;
        cyc(1);
        c_poll = 1'h0;
        c_ren = 1'h0;
        cyc(3);
        check({srq_pending, d_ren, ren_seen}, 9'h002);
        $display("test management done");
    endtask : t_mgmt
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    always @(posedge clock) begin
        if (rx_done === 1'h1) n_done++;
    end
    initial begin
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        end_sim;
    end
    initial begin
        cyc(20);
        rst = 1'h0;
        cyc(2);
        t_addr;
        t_talk;
        t_listen;
        t_err;
        t_mgmt;
        end_sim;
    end
endmodule : ghs_handshake_test

// file: ghs_peer.sv
`timescale 1ns/1ps
module ghs_peer (
    input wire logic clock,
    input wire logic [7:0] dio_n,
    input wire logic dav_n,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    input wire logic eoi_n,
    output logic [7:0] dio_oe_n,
    output logic dav_oe_n,
    output logic nrfd_oe_n,
    output logic ndac_oe_n,
    output logic eoi_oe_n
);
    logic [8:0] q[$];
    // idle: every line left to its pull-up
    initial begin
        {dio_oe_n, dav_oe_n, nrfd_oe_n, ndac_oe_n, eoi_oe_n} = 12'hFFF;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic listen(input int n, input int lat);
        {nrfd_oe_n, ndac_oe_n} = 2'h0;
        repeat (n) begin
            cyc(lat);
            nrfd_oe_n = 1'h1;
            while (dav_n) cyc(1);
            nrfd_oe_n = 1'h0;
            q.push_back({~eoi_n, ~dio_n});
            cyc(lat);
            ndac_oe_n = 1'h1;
            while (!dav_n) cyc(1);
            ndac_oe_n = 1'h0;
        end
        cyc(1);
        {nrfd_oe_n, ndac_oe_n} = 2'h3;
    endtask : listen
    task automatic talk(input logic [7:0] d, input logic last, input int lat);
        dio_oe_n = ~d;
        eoi_oe_n = ~last;
        cyc(lat);
        while (!nrfd_n) cyc(1);
        dav_oe_n = 1'h0;
        while (!ndac_n) cyc(1);
        {dav_oe_n, eoi_oe_n} = 2'h3;
        cyc(1);
        dio_oe_n = 8'hFF;
    endtask : talk
endmodule : ghs_peer

// file: ghs_pkg.sv
package ghs_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_MIN = 1;
    localparam int ADDR_MAX = 30;
    localparam int MAX_DEVICES = 15;
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_NS = 500;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] OWN_ADDR_RST = 5'h01;
    typedef enum logic [2:0] {
        GHS_IDLE,
        GHS_T_CHECK,
        GHS_T_SETTLE,
        GHS_T_WAIT_RFD,
        GHS_T_WAIT_DAC,
        GHS_L_READY,
        GHS_L_ACCEPT,
        GHS_L_WAIT_DAV_LOW
    } ghs_state_t;
endpackage : ghs_pkg

// file: ghs_sync.sv
`timescale 1ns/1ps
module ghs_sync #(
    parameter int W = 13
) (
    input wire logic clock,
    input wire logic rst,
    ghs_sync_if.snk sif
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;

    // first stage feeds only the second
    always_comb begin
        next_stage1 = sif.raw;
        next_stage2 = stage1;
    end

    // idle bus level: all lines released high
    always_ff @(posedge clock) begin
        if (rst) begin
            stage1 <= '1;
            stage2 <= '1;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sif.synced = stage2;
endmodule : ghs_sync

// file: ghs_sync_if.sv
`timescale 1ns/1ps
interface ghs_sync_if #(parameter int W = 13);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface : ghs_sync_if
